// File: pkg/phone_line_defines.svh
// Purpose: timing counts and constants for the phone line interface control
// Assumes: REF_CLK at 250 MHz
// Notes:   times in milliseconds, cycle counts derived from them
`ifndef PHONE_LINE_DEFINES_SVH
`define PHONE_LINE_DEFINES_SVH

`define CLK_FREQ_HZ        250000000
`define TONE_TIME_MS       1000
`define BLINK_TIME_MS      1000
`define RELEASE_TIME_MS    3000
`define MS_TO_CYCLES(ms)   ((ms) * (`CLK_FREQ_HZ / 1000))
`define TONE_CYCLES        `MS_TO_CYCLES(`TONE_TIME_MS)
`define BLINK_CYCLES       `MS_TO_CYCLES(`BLINK_TIME_MS)
`define RELEASE_CYCLES     `MS_TO_CYCLES(`RELEASE_TIME_MS)
`define RINGS_TO_ANSWER    2
`define MON_SRC_COUNT      5
`define ROUTE_SEND         2'h0
`define ROUTE_PROGRAM      2'h1
`define ROUTE_INTERRUPT    2'h2

`endif

// File: pkg/phone_line_pkg.sv
// Purpose: types for the phone line interface control
// Assumes: nothing
// Notes:   hook state machine encoding
package phone_line_pkg;

    typedef enum logic [1:0] {
        HOOK_ON,
        HOOK_WAIT_LOOP,
        HOOK_OFF
    } hook_state_t;

endpackage

// File: rtl/phone_line_ctrl.sv
// Purpose: hook, lamp, tone, routing and monitor mute control for a phone
//          line interface
// Assumes: all front-panel and line inputs asynchronous, two-flop synced
// Notes:   switch inputs are momentary and edge detected after sync
//
// Contract
// - shorted mode strap selects direct-audio mode; its lamp lit meanwhile
// - ringing lamp lit while ring detector reports alerting voltage
// - line-seized lamp steady while loop current detected, normal case
// - direct-audio mode with loop current blinks line-seized lamp
// - seize press in phone mode goes off-hook, one-second tone
// - after seize, stay off-hook with loop current, else timeout release
// - release press in phone mode goes on-hook
// - direct-audio mode ignores switches, always treated off-hook
// - selector: centre sends, left receive to program, right to interrupt
// - cue-feed monitor muted only while a mic talk function is active
// - auto answer after two complete ringing cycles, phone mode only
// - automatic answer sends one-second acknowledgment tone
// - mic-to-phone honoured off-hook in phone mode, always in direct mode
// - mic-to-phone active suspends normal receive and send paths
// - mic-to-phone active mutes cue-feed and main monitor outputs
// - main monitor muted when any of three mic talk functions active
// - five latching monitor selections, any combination, fed as a sum
// - mic-to-cue-feed pressed mutes cue-feed and main monitor outputs
// - mic to main and aux buses mutes main and cue-feed monitors
`timescale 1ns/1ns
`default_nettype none
`include "phone_line_defines.svh"
module phone_line_ctrl
    import phone_line_pkg::*;
#(
    parameter int TONE_CYCLES    = `TONE_CYCLES,
    parameter int BLINK_CYCLES   = `BLINK_CYCLES,
    parameter int RELEASE_CYCLES = `RELEASE_CYCLES,
    parameter int RING_COUNT     = `RINGS_TO_ANSWER,
    parameter int MON_SRCS       = `MON_SRC_COUNT
) (
    input  wire logic                REF_CLK,
    input  wire logic                RST_N,
    input  wire logic                MODE_STRAP_SHORTED,
    input  wire logic                RING_DETECT,
    input  wire logic                LOOP_CURRENT,
    input  wire logic                SEIZE_LINE_SWITCH,
    input  wire logic                RELEASE_LINE_SWITCH,
    input  wire logic                AUTO_ANSWER_ENABLE,
    input  wire logic                PROGRAM_ROUTE_POSITION,
    input  wire logic                INTERRUPT_ROUTE_POSITION,
    input  wire logic                MIC_TO_PHONE_BUTTON,
    input  wire logic                MIC_TO_CUE_FEED_BUTTON,
    input  wire logic                MIC_TO_MAIN_AUX_BUTTON,
    input  wire logic [MON_SRCS-1:0] MONITOR_SELECT_PRESS,
    output var  logic                DIRECT_AUDIO_LAMP,
    output var  logic                RINGING_LAMP,
    output var  logic                LINE_SEIZED_LAMP,
    output var  logic                OFF_HOOK,
    output var  logic                ACK_TONE_ON,
    output var  logic                SEND_PATH_ON,
    output var  logic                RECEIVE_TO_PROGRAM,
    output var  logic                RECEIVE_TO_INTERRUPT,
    output var  logic                MIC_TO_PHONE_ACTIVE,
    output var  logic                CUE_FEED_MONITOR_MUTE,
    output var  logic                MAIN_MONITOR_MUTE,
    output var  logic [MON_SRCS-1:0] MONITOR_SOURCE_SEL
);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers

    localparam int NIN = 12 + MON_SRCS;

    logic [NIN-1:0] sync1_ff;
    logic [NIN-1:0] sync2_ff;
    logic [NIN-1:0] prev_ff;
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] rise;

    assign raw_in = {MONITOR_SELECT_PRESS, MIC_TO_MAIN_AUX_BUTTON,
                     MIC_TO_CUE_FEED_BUTTON, MIC_TO_PHONE_BUTTON,
                     INTERRUPT_ROUTE_POSITION, PROGRAM_ROUTE_POSITION,
                     AUTO_ANSWER_ENABLE, RELEASE_LINE_SWITCH,
                     SEIZE_LINE_SWITCH, LOOP_CURRENT, RING_DETECT,
                     MODE_STRAP_SHORTED, 1'b0};

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            prev_ff  <= '0;
        end
        else
        begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    assign rise = sync2_ff & ~prev_ff;

    logic direct_mode;
    logic ring_s;
    logic loop_s;
    logic seize_press;
    logic release_press;
    logic auto_en;
    logic pos_program;
    logic pos_interrupt;
    logic talk_phone_btn;
    logic talk_cue_btn;
    logic talk_main_btn;
    logic ring_rise;
    logic ring_fall;
    logic [MON_SRCS-1:0] mon_press;

    assign direct_mode    = sync2_ff[1];
    assign ring_s         = sync2_ff[2];
    assign loop_s         = sync2_ff[3];
    assign seize_press    = rise[4];
    assign release_press  = rise[5];
    assign auto_en        = sync2_ff[6];
    assign pos_program    = sync2_ff[7];
    assign pos_interrupt  = sync2_ff[8];
    assign talk_phone_btn = sync2_ff[9];
    assign talk_cue_btn   = sync2_ff[10];
    assign talk_main_btn  = sync2_ff[11];
    assign mon_press      = rise[NIN-1:12];
    assign ring_rise      = rise[2];
    assign ring_fall      = prev_ff[2] & ~sync2_ff[2];

    ////////////////////////////////////////////////////////////////////////
    // timers

    logic tone_start;
    logic release_start;
    logic release_stop;
    logic release_expired;
    logic tone_running;
    logic blink_expired;
    logic blink_running;

    sync_timer #(.WIDTH(32)) u_tone_timer (
        .clk     (REF_CLK),
        .rst_n   (RST_N),
        .start   (tone_start),
        .stop    (1'b0),
        .load    (32'(TONE_CYCLES)),
        .running (tone_running),
        .expired ()
    );

    sync_timer #(.WIDTH(32)) u_release_timer (
        .clk     (REF_CLK),
        .rst_n   (RST_N),
        .start   (release_start),
        .stop    (release_stop),
        .load    (32'(RELEASE_CYCLES)),
        .running (),
        .expired (release_expired)
    );

    // free-running half-period timer for the blink cadence
    sync_timer #(.WIDTH(32)) u_blink_timer (
        .clk     (REF_CLK),
        .rst_n   (RST_N),
        .start   (~blink_running),
        .stop    (1'b0),
        .load    (32'(BLINK_CYCLES / 2)),
        .running (blink_running),
        .expired (blink_expired)
    );

    ////////////////////////////////////////////////////////////////////////
    // ring cycle counter for auto answer

    logic [3:0]  ring_cnt_ff;
    logic        auto_answer;
    hook_state_t state_ff;

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ring_cnt_ff <= '0;
        end
        else if (direct_mode || !auto_en || state_ff != HOOK_ON)
        begin
            ring_cnt_ff <= '0;
        end
        else if (ring_fall)
        begin
            ring_cnt_ff <= ring_cnt_ff + 4'h1;
        end
    end

    assign auto_answer = !direct_mode && auto_en && state_ff == HOOK_ON &&
                         ring_cnt_ff >= 4'(RING_COUNT);

    ////////////////////////////////////////////////////////////////////////
    // hook state machine

    hook_state_t nxt_state;

    always_comb
    begin
        nxt_state     = state_ff;
        tone_start    = 1'b0;
        release_start = 1'b0;
        release_stop  = 1'b0;
        unique case (state_ff)
            HOOK_ON:
            begin
                if (!direct_mode && seize_press)
                begin
                    nxt_state     = HOOK_WAIT_LOOP;
                    tone_start    = 1'b1;
                    release_start = 1'b1;
                end
                else if (auto_answer)
                begin
                    nxt_state     = HOOK_WAIT_LOOP;
                    tone_start    = 1'b1;
                    release_start = 1'b1;
                end
            end
            HOOK_WAIT_LOOP:
            begin
                if (!direct_mode && release_press)
                begin
                    nxt_state    = HOOK_ON;
                    release_stop = 1'b1;
                end
                else if (direct_mode || loop_s)
                begin
                    nxt_state    = HOOK_OFF;
                    release_stop = 1'b1;
                end
                else if (release_expired)
                begin
                    nxt_state = HOOK_ON;
                end
            end
            HOOK_OFF:
            begin
                if (!direct_mode && (release_press || !loop_s))
                begin
                    nxt_state = HOOK_ON;
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_ff <= HOOK_ON;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    logic off_hook;

    assign off_hook = direct_mode || state_ff != HOOK_ON;

    ////////////////////////////////////////////////////////////////////////
    // lamps

    logic blink_ff;

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            blink_ff <= 1'b0;
        end
        else if (blink_expired)
        begin
            blink_ff <= ~blink_ff;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            DIRECT_AUDIO_LAMP <= 1'b0;
            RINGING_LAMP      <= 1'b0;
            LINE_SEIZED_LAMP  <= 1'b0;
            OFF_HOOK          <= 1'b0;
            ACK_TONE_ON       <= 1'b0;
        end
        else
        begin
            DIRECT_AUDIO_LAMP <= direct_mode;
            RINGING_LAMP      <= ring_s;
            LINE_SEIZED_LAMP  <= loop_s &
                                 (blink_ff | ~direct_mode);
            OFF_HOOK    <= off_hook;
            ACK_TONE_ON <= tone_running && !direct_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // talk functions and routing

    logic talk_phone;
    logic any_talk;

    assign talk_phone = talk_phone_btn && off_hook;
    assign any_talk   = talk_phone || talk_cue_btn || talk_main_btn;

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            SEND_PATH_ON         <= 1'b0;
            RECEIVE_TO_PROGRAM   <= 1'b0;
            RECEIVE_TO_INTERRUPT <= 1'b0;
            MIC_TO_PHONE_ACTIVE  <= 1'b0;
        end
        else
        begin
            MIC_TO_PHONE_ACTIVE <= talk_phone;
            SEND_PATH_ON <= !talk_phone && !pos_program &&
                            !pos_interrupt;
            RECEIVE_TO_PROGRAM   <= !talk_phone && pos_program;
            RECEIVE_TO_INTERRUPT <= !talk_phone && !pos_program &&
                                    pos_interrupt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // monitor mutes and source selection

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            CUE_FEED_MONITOR_MUTE <= 1'b0;
            MAIN_MONITOR_MUTE     <= 1'b0;
        end
        else
        begin
            CUE_FEED_MONITOR_MUTE <= any_talk;
            MAIN_MONITOR_MUTE     <= any_talk;
        end
    end

    // each press toggles a latch; any mix may be on at once
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            MONITOR_SOURCE_SEL <= '0;
        end
        else
        begin
            MONITOR_SOURCE_SEL <= MONITOR_SOURCE_SEL ^ mon_press;
        end
    end

endmodule // phone_line_ctrl
`default_nettype wire

// File: rtl/sync_timer.sv
// Purpose: loadable down counter that reports expiry
// Assumes: single clock, asynchronous active-low reset
// Notes:   expired pulses one cycle after the count reaches one
`timescale 1ns/1ns
`default_nettype none
module sync_timer #(
    parameter int WIDTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             start,
    input  wire logic             stop,
    input  wire logic [WIDTH-1:0] load,
    output var  logic             running,
    output var  logic             expired
);

    logic [WIDTH-1:0] count_ff;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_ff <= '0;
            running  <= 1'b0;
            expired  <= 1'b0;
        end
        else
        begin
            expired <= 1'b0;
            if (start)
            begin
                count_ff <= load;
                running  <= 1'b1;
            end
            else if (stop)
            begin
                running <= 1'b0;
            end
            else if (running)
            begin
                if (count_ff <= 1)
                begin
                    running <= 1'b0;
                    expired <= 1'b1;
                end
                else
                begin
                    count_ff <= count_ff - 1'b1;
                end
            end
        end
    end

endmodule // sync_timer
`default_nettype wire

// File: test/phone_line_ctrl_assertions.sv
// Purpose: port-level checker for the phone line interface control
// Assumes: level outputs follow inputs three edges later
// Notes:   bound to every phone_line_ctrl instance
`timescale 1ns/1ns
`default_nettype none
module phone_line_ctrl_checker #(
    parameter int TONE_CYCLES    = 20,
    parameter int BLINK_CYCLES   = 8,
    parameter int RELEASE_CYCLES = 40
) (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic MODE_STRAP_SHORTED,
    input wire logic LOOP_CURRENT,
    input wire logic SEIZE_LINE_SWITCH,
    input wire logic MIC_TO_PHONE_BUTTON,
    input wire logic MIC_TO_CUE_FEED_BUTTON,
    input wire logic MIC_TO_MAIN_AUX_BUTTON,
    input wire logic DIRECT_AUDIO_LAMP,
    input wire logic LINE_SEIZED_LAMP,
    input wire logic OFF_HOOK,
    input wire logic ACK_TONE_ON,
    input wire logic CUE_FEED_MONITOR_MUTE,
    input wire logic MAIN_MONITOR_MUTE
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);
    logic [2:0] age_ff;
    logic [4:0] d1_ff, d2_ff, d3_ff;
    logic       lamp_q_ff;
    int         tone_ff, still_ff, idle_ff;
    logic       up;
    assign up = (age_ff == 3'h4);
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge REF_CLK)
    begin
        d1_ff <= {MIC_TO_MAIN_AUX_BUTTON, MIC_TO_CUE_FEED_BUTTON,
                  MIC_TO_PHONE_BUTTON, LOOP_CURRENT, MODE_STRAP_SHORTED};
        d2_ff <= d1_ff;
        d3_ff <= d2_ff;
        lamp_q_ff <= LINE_SEIZED_LAMP;
    end
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            age_ff <= 3'h0;
            tone_ff <= 0;
            still_ff <= 0;
            idle_ff <= 0;
        end
        else
        begin
            age_ff <= up ? age_ff : age_ff + 3'h1;
            tone_ff <= ACK_TONE_ON ? tone_ff + 1 : 0;
            still_ff <= (DIRECT_AUDIO_LAMP && d3_ff[1] &&
                         LINE_SEIZED_LAMP == lamp_q_ff) ? still_ff + 1 : 0;
            idle_ff <= (OFF_HOOK && !DIRECT_AUDIO_LAMP && !LOOP_CURRENT)
                       ? idle_ff + 1 : 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    chk_mode_lamp: assert property (
        up |-> DIRECT_AUDIO_LAMP == d3_ff[0])
        else $error("mode lamp does not follow the strap");
    chk_lamp_steady: assert property (
        up && !d3_ff[0] && d3_ff[1] |-> LINE_SEIZED_LAMP)
        else $error("seized lamp not steady with loop current");
    chk_lamp_blinks: assert property (still_ff <= BLINK_CYCLES)
        else $error("seized lamp not blinking in direct mode");
    chk_seize_hook: assert property (
        up && $rose(SEIZE_LINE_SWITCH) && !MODE_STRAP_SHORTED &&
        !DIRECT_AUDIO_LAMP && !OFF_HOOK |-> ##4 (OFF_HOOK && ACK_TONE_ON))
        else $error("seize press did not go off-hook with tone");
    chk_tone_length: assert property ($fell(ACK_TONE_ON) |->
        tone_ff >= TONE_CYCLES && tone_ff <= TONE_CYCLES + 1)
        else $error("tone length wrong");
    chk_no_loop_drop: assert property (idle_ff <= RELEASE_CYCLES + 8)
        else $error("off-hook without loop current too long");
    chk_direct_hook: assert property (
        DIRECT_AUDIO_LAMP[*3] |-> OFF_HOOK)
        else $error("direct mode not off-hook");
    chk_quiet_mutes: assert property (
        up && d3_ff[4:2] == 3'h0 |->
        !CUE_FEED_MONITOR_MUTE && !MAIN_MONITOR_MUTE)
        else $error("monitor muted with no talk function");
    chk_talk_mutes: assert property (
        up && (d3_ff[3] || d3_ff[4]) |->
        CUE_FEED_MONITOR_MUTE && MAIN_MONITOR_MUTE)
        else $error("monitors not muted during talk");
endmodule // phone_line_ctrl_checker
bind phone_line_ctrl phone_line_ctrl_checker #(
    .TONE_CYCLES(TONE_CYCLES), .BLINK_CYCLES(BLINK_CYCLES),
    .RELEASE_CYCLES(RELEASE_CYCLES)) chk_u (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .MODE_STRAP_SHORTED(MODE_STRAP_SHORTED),
    .LOOP_CURRENT(LOOP_CURRENT), .SEIZE_LINE_SWITCH(SEIZE_LINE_SWITCH),
    .MIC_TO_PHONE_BUTTON(MIC_TO_PHONE_BUTTON),
    .MIC_TO_CUE_FEED_BUTTON(MIC_TO_CUE_FEED_BUTTON),
    .MIC_TO_MAIN_AUX_BUTTON(MIC_TO_MAIN_AUX_BUTTON),
    .DIRECT_AUDIO_LAMP(DIRECT_AUDIO_LAMP), .LINE_SEIZED_LAMP(LINE_SEIZED_LAMP),
    .OFF_HOOK(OFF_HOOK), .ACK_TONE_ON(ACK_TONE_ON),
    .CUE_FEED_MONITOR_MUTE(CUE_FEED_MONITOR_MUTE),
    .MAIN_MONITOR_MUTE(MAIN_MONITOR_MUTE));
`default_nettype wire

// File: test/phone_line_far_end.sv
// Purpose: far-end line model giving ringing voltage and loop current
// Assumes: runs from the bench clock, outputs move just after an edge
// Notes:   ring is 8 cycles high, 8 low; loop flows only while off-hook
`timescale 1ns/1ns
`default_nettype none
module phone_line_far_end (
    input  wire logic clk,
    input  wire logic off_hook,
    input  wire logic line_up,
    input  wire logic ring_en,
    output var  logic ring_detect,
    output var  logic loop_current
);
    logic [3:0] cnt_ff = 4'h0;
    initial
    begin
        ring_detect = 1'b0;
        loop_current = 1'b0;
    end
    always @(posedge clk)
    begin
        cnt_ff <= ring_en ? cnt_ff + 4'h1 : 4'h0;
        ring_detect <= #1 ring_en & cnt_ff[3];
        loop_current <= #1 off_hook & line_up;
    end
endmodule // phone_line_far_end
`default_nettype wire

// File: test/phone_line_interface_control_tb_top.sv
// Purpose: self-checking bench for the phone line interface control
// Assumes: shortened counts through parameters
// Notes:   far-end model supplies ringing and loop current
`timescale 1ns/1ns
`default_nettype none
module phone_line_interface_control_tb_top;
    localparam int REL = 40;
    logic       clk = 1'b0, rst_n = 1'b0, strap = 1'b0, seize = 1'b0;
    logic       rel = 1'b0, auto = 1'b0, prog = 1'b0, intr = 1'b0;
    logic       micp = 1'b0, micc = 1'b0, micm = 1'b0, ring_en = 1'b0;
    logic       line_up = 1'b0;
    logic [4:0] mon = 5'h0, sel;
    logic       ring, loop, lamp_d, lamp_r, lamp_s, hook, tone, send;
    logic       rx_p, rx_i, talk, cue_m, main_m;
    int         bad_count = 0, checks = 0;
    always #2 clk = ~clk;
    phone_line_ctrl #(.TONE_CYCLES(20), .BLINK_CYCLES(8),
        .RELEASE_CYCLES(REL)) dut_u (
        .REF_CLK(clk), .RST_N(rst_n), .MODE_STRAP_SHORTED(strap),
        .RING_DETECT(ring), .LOOP_CURRENT(loop), .SEIZE_LINE_SWITCH(seize),
        .RELEASE_LINE_SWITCH(rel), .AUTO_ANSWER_ENABLE(auto),
        .PROGRAM_ROUTE_POSITION(prog), .INTERRUPT_ROUTE_POSITION(intr),
        .MIC_TO_PHONE_BUTTON(micp), .MIC_TO_CUE_FEED_BUTTON(micc),
        .MIC_TO_MAIN_AUX_BUTTON(micm), .MONITOR_SELECT_PRESS(mon),
        .DIRECT_AUDIO_LAMP(lamp_d), .RINGING_LAMP(lamp_r),
        .LINE_SEIZED_LAMP(lamp_s), .OFF_HOOK(hook), .ACK_TONE_ON(tone),
        .SEND_PATH_ON(send), .RECEIVE_TO_PROGRAM(rx_p),
        .RECEIVE_TO_INTERRUPT(rx_i), .MIC_TO_PHONE_ACTIVE(talk),
        .CUE_FEED_MONITOR_MUTE(cue_m), .MAIN_MONITOR_MUTE(main_m),
        .MONITOR_SOURCE_SEL(sel));
    phone_line_far_end line_u (.clk(clk), .off_hook(hook), .line_up(line_up),
        .ring_en(ring_en), .ring_detect(ring), .loop_current(loop));
    ////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic press(ref logic s);
        s = 1'b1;
        cyc(3);
        s = 1'b0;
    endtask
    task automatic chk(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR at %0t: got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk5(input logic [4:0] got, input logic [4:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_monitor;
        logic [4:0] exp;
        exp = 5'h0;
        for (int i = 0; i < 6; i++)
        begin
            mon = 5'h1 << (i % 5);
            exp = exp ^ mon;
            cyc(3);
            mon = 5'h0;
            cyc(4);
            chk5(sel, exp);
        end
    endtask
    task automatic t_talk;
        micp = 1'b1;
        cyc(5);
        chk(talk, 1'b0);
        micp = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            {micm, micc} = 2'(i);
            cyc(4);
            chk(cue_m, i != 0);
            chk(main_m, i != 0);
        end
        {micm, micc} = 2'h0;
    endtask
    task automatic t_seize;
        press(seize);
        cyc(1);
        chk(hook, 1'b1);
        chk(tone, 1'b1);
        cyc(REL + 8);
        chk(hook, 1'b0);
    endtask
    task automatic t_answer;
        line_up = 1'b1;
        press(seize);
        cyc(REL + 8);
        chk(hook, 1'b1);
        chk(lamp_s, 1'b1);
        press(rel);
        cyc(3);
        chk(hook, 1'b0);
        line_up = 1'b0;
    endtask
    task automatic t_ring;
        auto = 1'b1;
        line_up = 1'b1;
        ring_en = 1'b1;
        cyc(13);
        chk(lamp_r, 1'b1);
        cyc(14);
        chk(hook, 1'b0);
        cyc(12);
        chk(hook, 1'b1);
        chk(tone, 1'b1);
        ring_en = 1'b0;
        auto = 1'b0;
        cyc(24);
        chk(lamp_r, 1'b0);
        press(rel);
        cyc(3);
        line_up = 1'b0;
    endtask
    task automatic t_direct;
        logic on, off;
        on = 1'b0;
        off = 1'b0;
        strap = 1'b1;
        cyc(5);
        chk(lamp_d, 1'b1);
        press(rel);
        cyc(3);
        chk(hook, 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            {intr, prog} = 2'(i);
            cyc(4);
            chk(send, i == 0);
            chk(rx_p, i == 1);
            chk(rx_i, i == 2);
        end
        micp = 1'b1;
        cyc(4);
        chk(talk, 1'b1);
        chk(rx_i, 1'b0);
        chk(main_m, 1'b1);
        chk(cue_m, 1'b1);
        micp = 1'b0;
        {intr, prog} = 2'h0;
        line_up = 1'b1;
        cyc(6);
        repeat (16)
        begin
            cyc(1);
            on = on | lamp_s;
            off = off | !lamp_s;
        end
        chk(on & off, 1'b1);
        line_up = 1'b0;
        strap = 1'b0;
        cyc(8);
        chk(lamp_d, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        cyc(6);
        chk5(sel, 5'h0);
        rst_n = 1'b1;
        cyc(6);
        t_monitor;
        t_talk;
        t_seize;
        t_answer;
        t_ring;
        t_direct;
        final_report;
    end
    initial
    begin
        #20000;
        bad_count++;
        $display("ERROR at %0t: watchdog expired", $time);
        final_report;
    end
endmodule // phone_line_interface_control_tb_top
`default_nettype wire
